/* File: core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// processor core: apb master and refresh instruction
// ============================================================================
module core_model (
  input wire logic i_clk,
  input wire logic i_pready,
  output var logic o_psel = 1'b0,
  output var logic o_penable = 1'b0,
  output var logic o_pwrite = 1'b0,
  output var logic [11:0] o_paddr = 12'h000,
  output var logic [31:0] o_pwdata = 32'h0000_0000,
  output var logic o_refresh = 1'b0,
  output var logic o_hang = 1'b0
);
  // one transfer, request held until pready is sampled high or 50 cycles pass
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_pready !== 1'b1 && n < 50);
    if (n >= 50) o_hang <= 1'b1;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // released lines flip so a stale value is never mistaken for a live one
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask : xfer

  // one refresh: the first arms the watchdog, later ones restart it
  task automatic refresh();
    @(posedge i_clk);
    o_refresh <= 1'b1;
    @(posedge i_clk);
    o_refresh <= 1'b0;
  endtask : refresh
endmodule : core_model
`default_nettype wire

/* File: pin_sync3.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// three-stage pin synchroniser, change taken when stages two and three agree
// ============================================================================
module pin_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] P_IDLE = '0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_bit
    logic s1_q, s2_q, s3_q, lvl_q;
    // stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge i_clk)
    begin
      // stages start at the pin's idle level, so reset release makes no false edge
      if (i_reset)
      begin
        s1_q <= P_IDLE[g];
        s2_q <= P_IDLE[g];
        s3_q <= P_IDLE[g];
        lvl_q <= P_IDLE[g];
      end
      else
      begin
        s1_q <= i_async[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q)
          lvl_q <= s3_q;
      end
    end
    assign o_level[g] = lvl_q;
    assign o_rise[g] = s2_q & s3_q & ~lvl_q;
  end
endmodule : pin_sync3
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import watchdog_pkg::*;
  localparam int unsigned RC0 = 20;
  localparam int unsigned RC1 = 40;
  localparam int unsigned RC2 = 80;
  localparam int unsigned RC3 = 160;
  localparam int XT = 8; // crystal period in i_clk cycles
  logic i_clk, i_reset, xtal = 1'b0, first_clear_input_n = 1'b1, second_clear_input_n = 1'b1, lowv = 1'b0;
  logic halt = 1'b0, stop = 1'b0, xtal_run = 1'b0, refresh, psel, penable, pwrite, hang;
  logic stop_rec = 1'b0;
  logic pready, pslverr, core_rst, lv_rst, wd_rst;
  logic [1:0] xcnt = 2'b00;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [33:0] note;
  logic [33:0] exp_q [$];
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 24487;
  int n, h;
  int unsigned rc [4] = '{RC0, RC1, RC2, RC3};

  watchdog_por_lowvolt_reset #(.P_POR_CYCLES(50), .P_RC0(RC0), .P_RC1(RC1), .P_RC2(RC2),
    .P_RC3(RC3)) watchdog_por_lowvolt_reset_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_crystal_input_pin(xtal), .i_first_clear_input_n(first_clear_input_n),
    .i_second_clear_input_n(second_clear_input_n), .i_below_low_voltage_trip_level(lowv), .i_halt(halt),
    .i_stop(stop), .i_stop_recovery(stop_rec), .i_wdt_refresh(refresh), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_core_reset(core_rst),
    .o_low_voltage_reset(lv_rst), .o_watchdog_reset(wd_rst));

  core_model core_model_i (.i_clk(i_clk), .i_pready(pready), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
    .o_refresh(refresh), .o_hang(hang));

  // ==========================================================================
  // clocks
  // ==========================================================================
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // crystal stands still unless enabled, eight cycles a period when running
  always @(posedge i_clk)
  begin
    xcnt <= xcnt + 2'b01;
    if (xtal_run && xcnt == 2'b11) xtal <= ~xtal;
  end

  // ==========================================================================
  // checking
  // ==========================================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // a bus that never answers ends the run at once
  always @(posedge hang)
  begin
    error_cnt++;
    summarize();
  end

  // answers are compared mid-cycle with the oldest note in the queue
  always @(negedge i_clk)
  begin
    if (pready === 1'b1)
    begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
      check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) check("prdata", prdata, note[31:0]);
    end
  end

  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction : inr

  // ==========================================================================
  // bus and timing helpers
  // ==========================================================================
  task automatic rd(input logic [11:0] a, input logic err, input logic [31:0] d);
    exp_q.push_back({1'b1, err, d});
    core_model_i.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  // mode write, upper data bits random since only the low five matter
  task automatic wmode(input logic [4:0] m);
    logic [31:0] r;
    r = $random(seed);
    exp_q.push_back({2'b00, 32'h0000_0000});
    core_model_i.xfer(1'b1, MODE_ADDR, {r[31:5], m});
  endtask : wmode

  // bounded wait for the core to leave reset
  task automatic wait_run();
    int k;
    k = 0;
    do
    begin
      @(negedge i_clk);
      k++;
    end
    while (core_rst !== 1'b0 && k < 20000);
    if (k >= 20000)
    begin
      error_cnt++;
      summarize();
    end
  endtask : wait_run

  // cycles until expiry, then the core must be held in reset
  task automatic expire(output int cyc);
    cyc = 0;
    do
    begin
      @(negedge i_clk);
      cyc++;
    end
    while (wd_rst !== 1'b1 && cyc < 5000);
    if (cyc >= 5000)
    begin
      error_cnt++;
      summarize();
    end
    repeat (2) @(negedge i_clk);
    check("core reset after expiry", {31'h0, core_rst}, 32'h0000_0001);
    wait_run();
  endtask : expire

  // counts expiry pulses over a stretch of cycles
  task automatic quiet(input int cyc, output int hits);
    hits = 0;
    repeat (cyc)
    begin
      @(negedge i_clk);
      if (wd_rst === 1'b1) hits++;
    end
  endtask : quiet

  // a power-on run must start and still hold the core off 40 cycles later
  task automatic por_seen();
    int k;
    k = 0;
    while (core_rst !== 1'b1 && k < 10)
    begin
      @(negedge i_clk);
      k++;
    end
    check("core reset raised", {31'h0, core_rst}, 32'h0000_0001);
    repeat (40) @(negedge i_clk);
    check("power-on hold", {31'h0, core_rst}, 32'h0000_0001);
    wait_run();
  endtask : por_seen

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    i_reset = 1'b1;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    wait_run();
    rd(STATUS_ADDR, 1'b0, 32'(1) << ST_WINDOW_BIT);
    rd(MODE_ADDR, 1'b0, 32'h0000_0000);
    rd(12'h000, 1'b1, 32'h0000_0000);
    core_model_i.refresh();
    expire(n);
    check("default period", inr(n, RC1, RC1 + 6), 32'h0000_0001);
    for (int k = 0; k < 4; k++)
    begin
      wmode({3'b011, k[1:0]});
      core_model_i.refresh();
      expire(n);
      check("rc period", inr(n, rc[k], rc[k] + 6), 32'h0000_0001);
    end
    // refreshes at random spacing below the period keep it from expiring
    core_model_i.refresh();
    h = 0;
    repeat (10)
    begin
      quiet(5 + ({$random(seed)} % 25), n);
      h += n;
      core_model_i.refresh();
    end
    check("refreshed no expiry", h, 32'h0000_0000);
    expire(n);
    check("period from last refresh", inr(n, RC1, RC1 + 6), 32'h0000_0001);
    for (int k = 0; k < 2; k++)
    begin
      wmode(k == 0 ? 5'b01000 : 5'b00100);
      core_model_i.refresh();
      halt <= (k == 0);
      stop <= (k == 1);
      quiet(100, n);
      check("paused in low power", n, 32'h0000_0000);
      @(posedge i_clk);
      halt <= 1'b0;
      stop <= 1'b0;
      expire(n);
      check("resumed count", inr(n, RC0 - 4, RC0 + 6), 32'h0000_0001);
    end
    core_model_i.refresh();
    halt <= 1'b1;
    expire(n);
    check("counts in idle", inr(n, RC1, RC1 + 6), 32'h0000_0001);
    @(posedge i_clk);
    halt <= 1'b0;
    xtal_run <= 1'b1;
    wmode(5'b11100);
    core_model_i.refresh();
    stop <= 1'b1;
    quiet(2200, n);
    check("crystal stopped in sleep", n, 32'h0000_0000);
    @(posedge i_clk);
    stop <= 1'b0;
    core_model_i.refresh();
    expire(n);
    check("crystal period", inr(n, 255 * XT, 257 * XT + 8), 32'h0000_0001);
    repeat (WRITE_WINDOW_XTAL_CLOCKS * XT + 100) @(posedge i_clk);
    rd(STATUS_ADDR, 1'b0, 32'(1) << ST_WDT_CAUSE_BIT);
    wmode(5'b01100);
    // sleep recovery reopens the window, but the refused write stays refused
    @(posedge i_clk);
    stop_rec <= 1'b1;
    @(posedge i_clk);
    stop_rec <= 1'b0;
    rd(STATUS_ADDR, 1'b0, (32'(1) << ST_WDT_CAUSE_BIT) | (32'(1) << ST_WINDOW_BIT));
    core_model_i.refresh();
    expire(n);
    check("late write ignored", inr(n, RC1, RC1 + 6), 32'h0000_0001);
    xtal_run <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_clk);
      first_clear_input_n <= (k != 0);
      second_clear_input_n <= (k == 0);
      repeat (10) @(posedge i_clk);
      first_clear_input_n <= 1'b1;
      second_clear_input_n <= 1'b1;
      por_seen();
    end
    @(posedge i_clk);
    lowv <= 1'b1;
    repeat (8) @(negedge i_clk);
    check("low voltage flag", {31'h0, lv_rst}, 32'h0000_0001);
    repeat (200) @(negedge i_clk);
    check("low voltage hold", {31'h0, core_rst}, 32'h0000_0001);
    @(posedge i_clk);
    lowv <= 1'b0;
    por_seen();
    check("low voltage cleared", {31'h0, lv_rst}, 32'h0000_0000);
    check("bus answered", {31'h0, hang}, 32'h0000_0000);
    summarize();
  end
endmodule : testbench
`default_nettype wire

/* File: watchdog_pkg.sv */
package watchdog_pkg;

  // ==========================================================================
  // clock and derived timing
  // ==========================================================================
  localparam int CLK_MHZ = 200;
  // least times of the internal oscillator taps, in microseconds
  localparam int WDT_RC0_US = 5000;
  localparam int WDT_RC1_US = 10000;
  localparam int WDT_RC2_US = 20000;
  localparam int WDT_RC3_US = 80000;
  // one microsecond is a whole number of cycles, so no rounding is needed
  localparam int WDT_RC0_CYCLES = WDT_RC0_US * CLK_MHZ;
  localparam int WDT_RC1_CYCLES = WDT_RC1_US * CLK_MHZ;
  localparam int WDT_RC2_CYCLES = WDT_RC2_US * CLK_MHZ;
  localparam int WDT_RC3_CYCLES = WDT_RC3_US * CLK_MHZ;
  // crystal taps, in crystal_clock_period units
  localparam int WDT_XT0_CLOCKS = 256;
  localparam int WDT_XT1_CLOCKS = 512;
  localparam int WDT_XT2_CLOCKS = 1024;
  localparam int WDT_XT3_CLOCKS = 4096;
  // power-on one-shot, nominal
  localparam int POR_US = 5000;
  localparam int POR_CYCLES = POR_US * CLK_MHZ;
  localparam int RESET_TIMER_CLOCKS = 18;
  localparam int WRITE_WINDOW_XTAL_CLOCKS = 122;
  localparam int CNT_W = 24;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [7:0] MODE_IDX = 8'h0F;
  localparam logic [7:0] STATUS_IDX = 8'h10;
  localparam logic [11:0] MODE_ADDR = {2'b00, MODE_IDX, 2'b00};
  localparam logic [11:0] STATUS_ADDR = {2'b00, STATUS_IDX, 2'b00};
  localparam logic [7:0] MODE_RESET = 8'h0D;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_HALT_BIT = 2;
  localparam int MODE_STOP_BIT = 3;
  localparam int MODE_SRC_BIT = 4;
  localparam int ST_ENABLED_BIT = 0;
  localparam int ST_WINDOW_BIT = 1;
  localparam int ST_RESET_BIT = 2;
  localparam int ST_WDT_CAUSE_BIT = 3;
  localparam int ST_LOWV_BIT = 4;

  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_LOWV = 2'b01,
    SEQ_POR = 2'b10,
    SEQ_RST18 = 2'b11
  } seq_e;

endpackage : watchdog_pkg

/* File: watchdog_por_lowvolt_reset.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// watchdog, power-on and low-voltage reset unit
// ============================================================================
// What this block does
// R1: rc taps give 5, 10, 20, 80 ms
// R2: crystal taps give 256..4096 crystal periods
// R3: time select resets to code 01
// R4: bit 2 keeps counting in idle
// R5: bit 3 keeps counting in sleep
// R6: in sleep only rc source counts
// R7: bit 4 picks crystal, resets to rc
// R8: clear input rising starts both timers
// R9: low voltage holds global reset
// R10: recovery from low voltage runs power-on
// R11: expiry resets the whole processor
// R12: core refreshes once to enable, then periodically
// R13: mode writes only in first 122 crystal clocks
// R14: power-on one-shot holds execution off
// R15: refresh clears the watchdog count
module watchdog_por_lowvolt_reset
  import watchdog_pkg::*;
#(
  parameter int unsigned P_POR_CYCLES = POR_CYCLES,
  parameter int unsigned P_RC0 = WDT_RC0_CYCLES,
  parameter int unsigned P_RC1 = WDT_RC1_CYCLES,
  parameter int unsigned P_RC2 = WDT_RC2_CYCLES,
  parameter int unsigned P_RC3 = WDT_RC3_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_crystal_input_pin,
  input wire logic i_first_clear_input_n,
  input wire logic i_second_clear_input_n,
  input wire logic i_below_low_voltage_trip_level,
  input wire logic i_halt,
  input wire logic i_stop,
  input wire logic i_stop_recovery,
  input wire logic i_wdt_refresh,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_core_reset,
  output logic o_low_voltage_reset,
  output logic o_watchdog_reset
);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  wire [3:0] pin_level;
  wire [3:0] pin_rise;
  wire xtal_tick;
  wire clr_rise;
  wire lowv;

  pin_sync3 #(
    .WIDTH(4),
    .P_IDLE(4'b0110)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_below_low_voltage_trip_level, i_second_clear_input_n,
              i_first_clear_input_n, i_crystal_input_pin}),
    .o_level(pin_level),
    .o_rise(pin_rise)
  );

  // the crystal is sampled, so it must run well below a quarter of i_clk
  assign xtal_tick = pin_rise[0];
  assign clr_rise = pin_rise[1] | pin_rise[2];
  assign lowv = pin_level[3];

  // ==========================================================================
  // state
  // ==========================================================================
  seq_e seq_q, seq_d;
  logic [CNT_W-1:0] tmr_q, tmr_d;
  logic [7:0] mode_q;
  logic [7:0] win_cnt_q;
  logic win_q;
  logic en_q;
  logic wdt_cause_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic core_reset_q;
  logic lowv_reset_q;
  logic wdt_reset_q;

  wdt_ctl_if wd ();

  // ==========================================================================
  // reset sequencer
  // ==========================================================================
  wire running = (seq_q == SEQ_RUN);
  wire src_xtal = mode_q[MODE_SRC_BIT];
  wire src_tick = src_xtal ? xtal_tick : 1'b1; // R7
  wire por_done = (tmr_q >= CNT_W'(P_POR_CYCLES - 1));
  wire rst18_done = src_tick & (tmr_q >= CNT_W'(RESET_TIMER_CLOCKS - 1));
  wire restart = clr_rise | (running & wd.expire);

  // low voltage beats everything; a clear edge or expiry restarts power-on
  always_comb
  begin
    seq_d = seq_q;
    tmr_d = tmr_q;
    if (lowv)
    begin
      seq_d = SEQ_LOWV; // R9
      tmr_d = '0;
    end
    else if (restart && seq_q != SEQ_LOWV)
    begin
      seq_d = SEQ_POR; // R8 R11
      tmr_d = '0;
    end
    else
    begin
      case (seq_q)
        SEQ_LOWV:
        begin
          seq_d = SEQ_POR; // R10
          tmr_d = '0;
        end
        SEQ_POR:
        begin
          if (por_done)
          begin
            seq_d = SEQ_RST18; // R14
            tmr_d = '0;
          end
          else
            tmr_d = tmr_q + CNT_W'(1);
        end
        SEQ_RST18:
        begin
          if (rst18_done)
          begin
            seq_d = SEQ_RUN; // R8
            tmr_d = '0;
          end
          else if (src_tick)
            tmr_d = tmr_q + CNT_W'(1);
        end
        default:
          tmr_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      seq_q <= SEQ_POR;
      tmr_q <= '0;
    end
    else
    begin
      seq_q <= seq_d;
      tmr_q <= tmr_d;
    end
  end

  // core reset registered from the next state so it tracks it exactly; the other two from lowv and expiry
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      core_reset_q <= 1'b1;
      lowv_reset_q <= 1'b0;
      wdt_reset_q <= 1'b0;
    end
    else
    begin
      core_reset_q <= (seq_d != SEQ_RUN); // R14
      lowv_reset_q <= lowv; // R9
      wdt_reset_q <= running & wd.expire & ~lowv; // R11
    end
  end

  // cause flag: set by expiry, cleared by any other reset source
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      wdt_cause_q <= 1'b0;
    else if (running && wd.expire)
      wdt_cause_q <= 1'b1;
    else if (lowv || clr_rise)
      wdt_cause_q <= 1'b0;
  end

  // ==========================================================================
  // watchdog enable and tick gating
  // ==========================================================================
  // disabled by every reset; the first refresh arms it
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !running)
      en_q <= 1'b0;
    else if (i_wdt_refresh)
      en_q <= 1'b1; // R12
  end

  wire halt_pause = i_halt & ~mode_q[MODE_HALT_BIT]; // R4
  wire stop_pause = i_stop & (~mode_q[MODE_STOP_BIT] | src_xtal); // R5 R6
  assign wd.tick = en_q & running & src_tick & ~halt_pause & ~stop_pause;
  assign wd.clear = ~running | i_wdt_refresh; // R15
  assign wd.sel = mode_q[MODE_SEL_LSB +: 2];
  assign wd.src_xtal = src_xtal;

  wdt_counter #(
    .P_RC0(P_RC0),
    .P_RC1(P_RC1),
    .P_RC2(P_RC2),
    .P_RC3(P_RC3)
  ) u_wdt (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .ctl(wd.ctrl)
  );

  // ==========================================================================
  // apb slave: one wait state, answer registered
  // ==========================================================================
  wire access = i_psel & i_penable;
  wire first_access = access & ~pready_q;
  wire done = access & pready_q;
  wire hit_mode = (i_paddr == MODE_ADDR);
  wire hit_status = (i_paddr == STATUS_ADDR);
  wire mode_wr = done & i_pwrite & hit_mode & win_q & running; // R13
  wire [31:0] status_word = {27'h000_0000, lowv, wdt_cause_q, ~running, win_q, en_q};

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= first_access;
      pslverr_q <= first_access & ~hit_mode & ~hit_status;
      // the mode register is write only and reads as zero
      prdata_q <= (first_access & ~i_pwrite & hit_status) ? status_word : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // mode register and its write window
  // ==========================================================================
  // defaults return with every reset so a stale tap cannot survive one
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !running)
      mode_q <= MODE_RESET; // R3 R4 R5 R7
    else if (mode_wr)
      mode_q <= {3'b000, i_pwdata[4:0]};
  end

  // window opens as execution starts or on sleep recovery, counts crystal clocks
  // opening on the edge into run lets the first instructions reach the register
  always_ff @(posedge i_clk)
  begin
    if (i_reset || (!running && seq_d != SEQ_RUN))
    begin
      win_q <= 1'b0;
      win_cnt_q <= 8'h00;
    end
    else if (!running || i_stop_recovery)
    begin
      win_q <= 1'b1;
      win_cnt_q <= 8'h00;
    end
    else if (win_q && xtal_tick)
    begin
      win_cnt_q <= win_cnt_q + 8'h01;
      if (win_cnt_q >= 8'(WRITE_WINDOW_XTAL_CLOCKS - 1))
        win_q <= 1'b0; // R13
    end
  end

  // read data leaves from its own register, so it stands with pready
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_core_reset = core_reset_q;
  assign o_low_voltage_reset = lowv_reset_q;
  assign o_watchdog_reset = wdt_reset_q;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_lowv_holds_reset: assert property (lowv |=> core_reset_q && lowv_reset_q) // R9
    else $error("low voltage did not hold reset");
  chk_lowv_then_por: assert property (seq_q == SEQ_LOWV && !lowv |=> seq_q == SEQ_POR) // R10
    else $error("recovery skipped power-on");
  chk_por_length: assert property (seq_q == SEQ_POR && por_done && !lowv && !clr_rise
      |=> seq_q == SEQ_RST18 && core_reset_q) // R14
    else $error("power-on one-shot ended wrong");
  chk_por_bounded: assert property (seq_q == SEQ_POR |-> tmr_q < CNT_W'(P_POR_CYCLES)) // R14
    else $error("power-on timer overran");
  chk_clear_restart: assert property (clr_rise && !lowv |=> seq_q == SEQ_POR && tmr_q == '0) // R8
    else $error("clear edge did not restart timers");
  chk_expiry_reset: assert property (running && wd.expire && !lowv
      |=> seq_q == SEQ_POR ##1 core_reset_q) // R11
    else $error("expiry did not reset the core");
  chk_mode_default: assert property (seq_q == SEQ_LOWV |=> mode_q[1:0] == 2'b01
      && mode_q[MODE_HALT_BIT] && mode_q[MODE_STOP_BIT] && !mode_q[MODE_SRC_BIT]) // R3
    else $error("mode defaults wrong after reset");
  chk_write_locked: assert property (done && i_pwrite && hit_mode && !win_q && running
      |=> $stable(mode_q)) // R13
    else $error("late mode write accepted");
  chk_halt_pause: assert property (i_halt && !mode_q[MODE_HALT_BIT] |-> !wd.tick) // R4
    else $error("watchdog ran in idle");
  chk_stop_pause: assert property (i_stop && (src_xtal || !mode_q[MODE_STOP_BIT])
      |-> !wd.tick) // R5
    else $error("watchdog ran in sleep");
  chk_refresh_arms: assert property (running && i_wdt_refresh |=> en_q || !running) // R12
    else $error("refresh did not arm the watchdog");
  chk_window_opens: assert property (!running && seq_d == SEQ_RUN |=> win_q) // R13
    else $error("write window did not open on entering run");
  chk_window_closes: assert property (running && !i_stop_recovery && win_q && xtal_tick
      && win_cnt_q == 8'(WRITE_WINDOW_XTAL_CLOCKS - 1) |=> !win_q) // R13
    else $error("write window did not close");

  cov_wdt_expiry: cover property (running && wd.expire);
  cov_lowv_recover: cover property (seq_q == SEQ_LOWV ##1 seq_q == SEQ_POR);
  cov_mode_write: cover property (mode_wr);
  cov_back_to_run: cover property (seq_q == SEQ_RST18 ##1 seq_q == SEQ_RUN);
  cov_window_reopen: cover property (running && i_stop_recovery);

endmodule : watchdog_por_lowvolt_reset
`default_nettype wire

/* File: wdt_counter.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// retriggerable watchdog count with tap select
// ============================================================================
module wdt_counter
  import watchdog_pkg::*;
#(
  parameter int unsigned P_RC0 = WDT_RC0_CYCLES,
  parameter int unsigned P_RC1 = WDT_RC1_CYCLES,
  parameter int unsigned P_RC2 = WDT_RC2_CYCLES,
  parameter int unsigned P_RC3 = WDT_RC3_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  wdt_ctl_if.cnt ctl
);
  logic [CNT_W-1:0] count_q;
  logic expire_q;
  wire [CNT_W-1:0] limit;
  wire last_tick;

  // tap select: crystal counts are periods of the pin, rc counts are cycles
  assign limit = ctl.src_xtal ?
    (ctl.sel == 2'b00 ? CNT_W'(WDT_XT0_CLOCKS) : ctl.sel == 2'b01 ? CNT_W'(WDT_XT1_CLOCKS) :
     ctl.sel == 2'b10 ? CNT_W'(WDT_XT2_CLOCKS) : CNT_W'(WDT_XT3_CLOCKS)) :
    (ctl.sel == 2'b00 ? CNT_W'(P_RC0) : ctl.sel == 2'b01 ? CNT_W'(P_RC1) :
     ctl.sel == 2'b10 ? CNT_W'(P_RC2) : CNT_W'(P_RC3)); // R1 R2
  assign last_tick = ctl.tick & (count_q >= limit - CNT_W'(1));
  assign ctl.expire = expire_q;

  // refresh wins over a tick in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_reset || ctl.clear)
      count_q <= '0; // R15
    else if (last_tick)
      count_q <= '0;
    else if (ctl.tick)
      count_q <= count_q + CNT_W'(1);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      expire_q <= 1'b0;
    else
      expire_q <= last_tick & ~ctl.clear; // R11
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  chk_refresh_clears: assert property (ctl.clear |=> count_q == '0 && !expire_q) // R15
    else $error("refresh did not clear the count");
  chk_terminal_expire: assert property (last_tick && !ctl.clear |=> expire_q) // R1
    else $error("terminal count did not expire");
  chk_xtal_tap: assert property (ctl.src_xtal && ctl.sel == 2'b00 && expire_q
      |-> $past(count_q) == CNT_W'(WDT_XT0_CLOCKS - 1)) // R2
    else $error("crystal tap length wrong");
endmodule : wdt_counter
`default_nettype wire

/* File: wdt_ctl_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// control between the sequencer and the watchdog counter
// ============================================================================
interface wdt_ctl_if;
  logic tick;
  logic clear;
  logic [1:0] sel;
  logic src_xtal;
  logic expire;
  modport ctrl (output tick, output clear, output sel, output src_xtal, input expire);
  modport cnt (input tick, input clear, input sel, input src_xtal, output expire);
endinterface : wdt_ctl_if
`default_nettype wire
